/* File: logic/bfl_exec.sv */
`timescale 1ns/1ns
`default_nettype none
module bfl_exec #(
    parameter int          NUM_REGS = 16,
    parameter logic [15:0] SP_RESET = bfl_pkg::SP_RESET_DEFAULT
) (
    input  wire logic                   clk_sys_in,
    input  wire logic                   sys_rst_in,
    input  wire logic                   ce_in,
    input  wire logic                   instr_valid_in,
    input  wire bfl_pkg::bfl_op_t       instr_op_in,
    input  wire logic [3:0]             instr_rd_in,
    input  wire logic [3:0]             instr_rr_in,
    input  wire logic [2:0]             instr_bit_in,
    input  wire logic [1:0]             instr_ptr_sel_in,
    input  wire bfl_pkg::bfl_ptr_mode_t instr_ptr_mode_in,
    input  wire logic [15:0]            instr_addr_in,
    input  wire logic [7:0]             instr_imm_in,
    input  wire logic [7:0]             mem_rdata_in,
    input  wire logic [7:0]             io_rdata_in,
    output logic                        instr_ready_out,
    output logic [15:0]                 mem_addr_out,
    output logic [7:0]                  mem_wdata_out,
    output logic                        mem_we_out,
    output logic                        mem_re_out,
    output logic [5:0]                  io_addr_out,
    output logic [7:0]                  io_wdata_out,
    output logic                        io_we_out,
    output logic                        io_re_out,
    output logic                        io_bit_clear_out,
    output logic [7:0]                  status_flags_out,
    output logic [15:0]                 stack_ptr_out,
    output logic                        wdog_restart_out,
    output logic                        sleep_req_out,
    output logic                        break_req_out
);

    // The pointer indices and the 4-bit register fields assume sixteen registers.
    if (NUM_REGS != 16) begin : g_bad_regs
        $error("bfl_exec supports exactly sixteen working registers");
    end

    logic [7:0]  rf_q [NUM_REGS];
    logic [7:0]  fwd [NUM_REGS];
    logic [15:0] sp_q;
    logic        ex_load_q;
    logic        ex_from_io_q;
    logic [3:0]  ex_rd_q;
    logic [15:0] mem_addr_q;
    logic [7:0]  mem_wdata_q;
    logic        mem_we_q;
    logic        mem_re_q;
    logic [5:0]  io_addr_q;
    logic [7:0]  io_wdata_q;
    logic        io_we_q;
    logic        io_re_q;
    logic        io_clr_q;
    logic        wdog_q;
    logic        sleep_q;
    logic        break_q;
    logic        ready;
    logic [7:0]  flags;

    // Pointer register index of the low byte for a pointer selection.
    function automatic logic [3:0] ptr_lo(input logic [1:0] sel);
        ptr_lo = (sel == bfl_pkg::PTR_SEL_X) ? bfl_pkg::PTR_X_LO :
                 (sel == bfl_pkg::PTR_SEL_Y) ? bfl_pkg::PTR_Y_LO : bfl_pkg::PTR_Z_LO;
    endfunction : ptr_lo

    // Decode of the accepted instruction.
    wire take       = ce_in & instr_valid_in & ready;
    wire is_ld_ind  = take & (instr_op_in == bfl_pkg::OP_INDIRECT_READ);
    wire is_st_ind  = take & (instr_op_in == bfl_pkg::OP_INDIRECT_WRITE);
    wire is_ld_dir  = take & (instr_op_in == bfl_pkg::OP_DIRECT_READ);
    wire is_st_dir  = take & (instr_op_in == bfl_pkg::OP_DIRECT_WRITE);
    wire is_io_rd   = take & (instr_op_in == bfl_pkg::OP_IO_READ);
    wire is_io_wr   = take & (instr_op_in == bfl_pkg::OP_IO_WRITE);
    wire is_io_clr  = take & (instr_op_in == bfl_pkg::OP_IO_BIT_CLEAR);
    wire is_push    = take & (instr_op_in == bfl_pkg::OP_PUSH);
    wire is_pop     = take & (instr_op_in == bfl_pkg::OP_POP);
    wire is_mov     = take & (instr_op_in == bfl_pkg::OP_REGISTER_COPY);
    wire is_ldi     = take & (instr_op_in == bfl_pkg::OP_IMMEDIATE_LOAD);
    wire is_bld     = take & (instr_op_in == bfl_pkg::OP_T_TO_BIT);
    wire is_bst     = take & (instr_op_in == bfl_pkg::OP_BIT_TO_T);
    wire is_set     = take & (instr_op_in == bfl_pkg::OP_FLAG_FORCE_ONE);
    wire is_clr     = take & (instr_op_in == bfl_pkg::OP_FLAG_FORCE_ZERO);
    wire is_wdr     = take & (instr_op_in == bfl_pkg::OP_WATCHDOG_RESTART);
    wire is_sleep   = take & (instr_op_in == bfl_pkg::OP_SLEEP);
    wire is_break   = take & (instr_op_in == bfl_pkg::OP_BREAK);
    wire post_inc   = (instr_ptr_mode_in == bfl_pkg::PM_POST_INC);
    wire pre_dec    = (instr_ptr_mode_in == bfl_pkg::PM_PRE_DEC);

    // Load data returns in the cycle after acceptance and is forwarded at once.
    wire [7:0] ld_data = ex_from_io_q ? io_rdata_in : mem_rdata_in;

    for (genvar i = 0; i < NUM_REGS; i++) begin : g_fwd
        assign fwd[i] = (ex_load_q && ex_rd_q == 4'(i)) ? ld_data : rf_q[i];
    end

    // Operand and pointer selection.
    wire [3:0]  p_lo     = ptr_lo(instr_ptr_sel_in);
    wire [3:0]  p_hi     = p_lo + 4'h1;
    wire [15:0] ptr_val  = {fwd[p_hi], fwd[p_lo]};
    wire [15:0] ptr_dec  = ptr_val - bfl_pkg::ADDR_ONE;
    wire [15:0] ptr_inc  = ptr_val + bfl_pkg::ADDR_ONE;
    wire [15:0] eff_addr = pre_dec ? ptr_dec : ptr_val;
    wire [15:0] ptr_new  = pre_dec ? ptr_dec : ptr_inc;
    wire        ptr_wr   = (is_ld_ind | is_st_ind) & (pre_dec | post_inc);
    wire [7:0]  src_rr   = fwd[instr_rr_in];
    wire [7:0]  src_rd   = fwd[instr_rd_in];
    wire [7:0]  bit_mask = bfl_pkg::BIT_ONE << instr_bit_in;
    wire        t_flag   = flags[bfl_pkg::FLAG_TRANSFER];

    // Accept-stage register write: copy, immediate and T-to-bit.
    wire        wa_en   = is_mov | is_ldi | is_bld;
    wire [7:0]  wa_data = is_mov ? src_rr :
                          is_ldi ? instr_imm_in :
                          (t_flag ? (src_rd | bit_mask) : (src_rd & ~bit_mask));

    // Memory request of the accepted op, and whether it loads a register.
    wire        mem_re_d   = is_ld_ind | is_ld_dir | is_pop;
    wire        mem_we_d   = is_st_ind | is_st_dir | is_push;
    wire [15:0] sp_inc     = sp_q + bfl_pkg::ADDR_ONE;
    wire [15:0] mem_addr_d = (is_ld_ind | is_st_ind) ? eff_addr :
                             is_push ? sp_q :
                             is_pop  ? sp_inc :
                             instr_addr_in;
    wire [15:0] sp_d       = is_push ? (sp_q - bfl_pkg::ADDR_ONE) : is_pop ? sp_inc : sp_q;
    wire        load_d     = mem_re_d | is_io_rd;

    // Extra occupancy: post-inc and pre-dec reads, pre-dec writes, push and pop.
    wire        two_cycle  = (is_ld_ind & (post_inc | pre_dec)) |
                             (is_st_ind & pre_dec) |
                             is_push | is_pop;
    wire [1:0]  extra      = two_cycle ? bfl_pkg::EXTRA_ONE : bfl_pkg::EXTRA_NONE;

    // Working register file; pointer and accept writes beat a late load result.
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_rf
        always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                rf_q[i] <= bfl_pkg::BYTE_ZERO;
            end else if (ce_in) begin
                if (ptr_wr && p_lo == 4'(i)) begin
                    rf_q[i] <= ptr_new[7:0];
                end else if (ptr_wr && p_hi == 4'(i)) begin
                    rf_q[i] <= ptr_new[15:8];
                end else if (wa_en && instr_rd_in == 4'(i)) begin
                    rf_q[i] <= wa_data;
                end else if (ex_load_q && ex_rd_q == 4'(i)) begin
                    rf_q[i] <= ld_data;
                end
            end
        end
    end

    // Second stage: captures which register the returning byte belongs to.
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ex_load_q    <= 1'b0;
            ex_from_io_q <= 1'b0;
            ex_rd_q      <= 4'h0;
            sp_q         <= SP_RESET;
        end else if (ce_in) begin
            ex_load_q    <= load_d;
            ex_from_io_q <= is_io_rd;
            ex_rd_q      <= instr_rd_in;
            sp_q         <= sp_d;
        end
    end

    // Data memory request registers.
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mem_addr_q  <= 16'h0000;
            mem_wdata_q <= bfl_pkg::BYTE_ZERO;
            mem_we_q    <= 1'b0;
            mem_re_q    <= 1'b0;
        end else if (ce_in) begin
            mem_addr_q  <= mem_addr_d;
            mem_wdata_q <= src_rr;
            mem_we_q    <= mem_we_d;
            mem_re_q    <= mem_re_d;
        end
    end

    // I/O request registers; a bit clear sends the bit mask on the write data.
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            io_addr_q  <= 6'h00;
            io_wdata_q <= bfl_pkg::BYTE_ZERO;
            io_we_q    <= 1'b0;
            io_re_q    <= 1'b0;
            io_clr_q   <= 1'b0;
        end else if (ce_in) begin
            io_addr_q  <= instr_addr_in[5:0];
            io_wdata_q <= is_io_clr ? bit_mask : src_rr;
            io_we_q    <= is_io_wr;
            io_re_q    <= is_io_rd;
            io_clr_q   <= is_io_clr;
        end
    end

    // Core-control pulses, one cycle each.
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wdog_q  <= 1'b0;
            sleep_q <= 1'b0;
            break_q <= 1'b0;
        end else if (ce_in) begin
            wdog_q  <= is_wdr;
            sleep_q <= is_sleep;
            break_q <= is_break;
        end
    end

    // Status flags change only on flag forces and bit-to-T.
    bfl_flag_unit u_flags (
        .clk_sys_in    (clk_sys_in),
        .sys_rst_in    (sys_rst_in),
        .ce_in         (ce_in),
        .force_one_in  (is_set),
        .force_zero_in (is_clr),
        .load_t_in     (is_bst),
        .flag_sel_in   (instr_bit_in),
        .t_value_in    (|(src_rr & bit_mask)),
        .flags_out     (flags)
    );

    // Occupancy counter that gates acceptance.
    bfl_stall_ctr u_stall (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .take_in    (take),
        .extra_in   (extra),
        .ready_out  (ready)
    );

    // All outputs come straight from flip-flops.
    assign instr_ready_out  = ready;
    assign mem_addr_out     = mem_addr_q;
    assign mem_wdata_out    = mem_wdata_q;
    assign mem_we_out       = mem_we_q;
    assign mem_re_out       = mem_re_q;
    assign io_addr_out      = io_addr_q;
    assign io_wdata_out     = io_wdata_q;
    assign io_we_out        = io_we_q;
    assign io_re_out        = io_re_q;
    assign io_bit_clear_out = io_clr_q;
    assign status_flags_out = flags;
    assign stack_ptr_out    = sp_q;
    assign wdog_restart_out = wdog_q;
    assign sleep_req_out    = sleep_q;
    assign break_req_out    = break_q;

endmodule : bfl_exec
`default_nettype wire

/* File: logic/bfl_pkg.sv */
package bfl_pkg;

    // Operation codes handed over by the fetch stage.
    typedef enum logic [4:0] {
        OP_NO_OPERATION     = 5'h00,
        OP_BREAK            = 5'h01,
        OP_SLEEP            = 5'h02,
        OP_WATCHDOG_RESTART = 5'h03,
        OP_IO_BIT_CLEAR     = 5'h04,
        OP_BIT_TO_T         = 5'h05,
        OP_T_TO_BIT         = 5'h06,
        OP_FLAG_FORCE_ONE   = 5'h07,
        OP_FLAG_FORCE_ZERO  = 5'h08,
        OP_REGISTER_COPY    = 5'h09,
        OP_IMMEDIATE_LOAD   = 5'h0a,
        OP_INDIRECT_READ    = 5'h0b,
        OP_INDIRECT_WRITE   = 5'h0c,
        OP_DIRECT_READ      = 5'h0d,
        OP_DIRECT_WRITE     = 5'h0e,
        OP_IO_READ          = 5'h0f,
        OP_IO_WRITE         = 5'h10,
        OP_PUSH             = 5'h11,
        OP_POP              = 5'h12
    } bfl_op_t;

    // Pointer addressing modes.
    typedef enum logic [1:0] {
        PM_PLAIN    = 2'h0,
        PM_POST_INC = 2'h1,
        PM_PRE_DEC  = 2'h2
    } bfl_ptr_mode_t;

    // Status flag positions in status_flags_out.
    localparam logic [2:0] FLAG_CARRY    = 3'h0;
    localparam logic [2:0] FLAG_ZERO     = 3'h1;
    localparam logic [2:0] FLAG_NEGATIVE = 3'h2;
    localparam logic [2:0] FLAG_OVERFLOW = 3'h3;
    localparam logic [2:0] FLAG_SIGN     = 3'h4;
    localparam logic [2:0] FLAG_HALF     = 3'h5;
    localparam logic [2:0] FLAG_TRANSFER = 3'h6;
    localparam logic [2:0] FLAG_IRQ      = 3'h7;

    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Register file indices of the low bytes of the three pointers.
    localparam logic [3:0] PTR_X_LO = 4'ha;
    localparam logic [3:0] PTR_Y_LO = 4'hc;
    localparam logic [3:0] PTR_Z_LO = 4'he;
    localparam logic [1:0] PTR_SEL_X = 2'h0;
    localparam logic [1:0] PTR_SEL_Y = 2'h1;

    // Extra cycles after the accepting cycle, per operation class.
    localparam logic [1:0] EXTRA_NONE = 2'h0;
    localparam logic [1:0] EXTRA_ONE  = 2'h1;

    localparam logic [15:0] ADDR_ONE = 16'h0001;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [7:0]  BIT_ONE   = 8'h01;
    localparam logic [15:0] SP_RESET_DEFAULT = 16'h00ff;

endpackage : bfl_pkg

/* File: logic/bfl_flag_unit.sv */
`timescale 1ns/1ns
`default_nettype none
module bfl_flag_unit (
    input  wire logic       clk_sys_in,
    input  wire logic       sys_rst_in,
    input  wire logic       ce_in,
    input  wire logic       force_one_in,
    input  wire logic       force_zero_in,
    input  wire logic       load_t_in,
    input  wire logic [2:0] flag_sel_in,
    input  wire logic       t_value_in,
    output logic      [7:0] flags_out
);

    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] sel_mask;

    // One-hot mask of the single flag an instruction may touch.
    assign sel_mask = BIT_MASK(force_one_in | force_zero_in ? flag_sel_in
                                                           : bfl_pkg::FLAG_TRANSFER);

    function automatic logic [7:0] BIT_MASK(input logic [2:0] pos);
        BIT_MASK = bfl_pkg::BIT_ONE << pos;
    endfunction : BIT_MASK

    // Only the selected flag changes; all others keep their value.
    assign flags_d = force_one_in  ? (flags_q | sel_mask) :
                     force_zero_in ? (flags_q & ~sel_mask) :
                     load_t_in     ? (t_value_in ? (flags_q | sel_mask)
                                                 : (flags_q & ~sel_mask)) :
                     flags_q;

    // Status register storage.
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flags_q <= bfl_pkg::STATUS_RESET;
        end else if (ce_in) begin
            flags_q <= flags_d;
        end
    end

    assign flags_out = flags_q;

endmodule : bfl_flag_unit
`default_nettype wire

/* File: logic/bfl_stall_ctr.sv */
`timescale 1ns/1ns
`default_nettype none
module bfl_stall_ctr (
    input  wire logic       clk_sys_in,
    input  wire logic       sys_rst_in,
    input  wire logic       ce_in,
    input  wire logic       take_in,
    input  wire logic [1:0] extra_in,
    output logic            ready_out
);

    logic [1:0] cnt_q;
    logic       ready_q;

    // Holds the fetch side off for the extra cycles of a multi-cycle op.
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_q   <= bfl_pkg::EXTRA_NONE;
            ready_q <= 1'b1;
        end else if (ce_in) begin
            if (take_in) begin
                cnt_q   <= extra_in;
                ready_q <= (extra_in == bfl_pkg::EXTRA_NONE);
            end else if (cnt_q != bfl_pkg::EXTRA_NONE) begin
                cnt_q   <= cnt_q - bfl_pkg::EXTRA_ONE;
                ready_q <= (cnt_q == bfl_pkg::EXTRA_ONE);
            end
        end
    end

    assign ready_out = ready_q;

endmodule : bfl_stall_ctr
`default_nettype wire

/* File: tb/bfl_exec_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module bfl_exec_properties (
    input wire logic                   clk_sys_in,
    input wire logic                   sys_rst_in,
    input wire logic                   ce_in,
    input wire logic                   instr_valid_in,
    input wire bfl_pkg::bfl_op_t       instr_op_in,
    input wire logic [2:0]             instr_bit_in,
    input wire bfl_pkg::bfl_ptr_mode_t instr_ptr_mode_in,
    input wire logic [15:0]            instr_addr_in,
    input wire logic                   instr_ready_out,
    input wire logic [15:0]            mem_addr_out,
    input wire logic                   mem_we_out,
    input wire logic                   mem_re_out,
    input wire logic [7:0]             io_wdata_out,
    input wire logic                   io_bit_clear_out,
    input wire logic [7:0]             status_flags_out,
    input wire logic                   wdog_restart_out,
    input wire logic                   sleep_req_out
);
    // Take strobe, the slow operations and the one-hot bit mask of the offered op.
    wire       tk = ce_in && instr_valid_in && instr_ready_out;
    wire       pp = instr_op_in == bfl_pkg::OP_PUSH || instr_op_in == bfl_pkg::OP_POP;
    wire       direct_read = instr_op_in == bfl_pkg::OP_INDIRECT_READ;
    wire       sts = instr_op_in == bfl_pkg::OP_INDIRECT_WRITE;
    wire       slow = pp || (direct_read && instr_ptr_mode_in != bfl_pkg::PM_PLAIN)
                  || (sts && instr_ptr_mode_in == bfl_pkg::PM_PRE_DEC);
    wire       f1 = instr_op_in == bfl_pkg::OP_FLAG_FORCE_ONE;
    wire       f0 = instr_op_in == bfl_pkg::OP_FLAG_FORCE_ZERO;
    wire       ft = instr_op_in == bfl_pkg::OP_BIT_TO_T;
    wire [7:0] fm = 8'h01 << instr_bit_in;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    // A slow op holds the core for exactly one cycle.
    sequence s_stall;
        !instr_ready_out ##1 instr_ready_out;
    endsequence

    a_slow_stall: assert property (tk && slow |=> s_stall)
        else $error("slow op stall");
    a_fast_ready: assert property (tk && !slow |=> instr_ready_out)
        else $error("fast op stalled");
    a_force_one: assert property (tk && f1 |=>
        status_flags_out == ($past(status_flags_out) | $past(fm)))
        else $error("force one");
    a_force_zero: assert property (tk && f0 |=>
        status_flags_out == ($past(status_flags_out) & ~$past(fm)))
        else $error("force zero");
    a_t_only: assert property (tk && ft |=>
        (status_flags_out & 8'hbf) == ($past(status_flags_out) & 8'hbf))
        else $error("bit store flags");
    a_flags_kept: assert property (tk && !(f1 || f0 || ft) |=> $stable(status_flags_out))
        else $error("flags changed");
    a_clear_mask: assert property (tk && instr_op_in == bfl_pkg::OP_IO_BIT_CLEAR |=>
        io_bit_clear_out && io_wdata_out == $past(fm))
        else $error("bit clear");
    a_direct_rd: assert property (tk && instr_op_in == bfl_pkg::OP_DIRECT_READ |=>
        mem_re_out && mem_addr_out == $past(instr_addr_in))
        else $error("direct read");
    a_direct_wr: assert property (tk && instr_op_in == bfl_pkg::OP_DIRECT_WRITE |=>
        mem_we_out && mem_addr_out == $past(instr_addr_in))
        else $error("direct write");
    a_post_store: assert property (tk && sts && instr_ptr_mode_in == bfl_pkg::PM_POST_INC
        |=> mem_we_out && instr_ready_out)
        else $error("post-inc store");
    a_wdog_pulse: assert property (tk && instr_op_in == bfl_pkg::OP_WATCHDOG_RESTART |=>
        wdog_restart_out)
        else $error("restart pulse");
    a_sleep_pulse: assert property (tk && instr_op_in == bfl_pkg::OP_SLEEP |=>
        sleep_req_out)
        else $error("sleep request");
endmodule : bfl_exec_properties

bind bfl_exec bfl_exec_properties i_bfl_exec_properties (.*);
`default_nettype wire

/* File: tb/bfl_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module bfl_mem_model (
    input  wire logic        clk_sys_in,
    input  wire logic [15:0] mem_addr_in,
    input  wire logic [7:0]  mem_wdata_in,
    input  wire logic        mem_we_in,
    input  wire logic        mem_re_in,
    input  wire logic [5:0]  io_addr_in,
    input  wire logic [7:0]  io_wdata_in,
    input  wire logic        io_we_in,
    input  wire logic        io_re_in,
    input  wire logic        io_clr_in,
    output logic      [7:0]  mem_rdata_out,
    output logic      [7:0]  io_rdata_out
);
    logic [7:0] mem [256];
    logic [7:0] io [64];

    // Byte i of data space starts as i xor 5a so that every load has a known value.
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
        for (int i = 0; i < 64; i++) io[i] = 8'h00;
    end

    // Read data is valid only under its strobe; otherwise it is scrambled on purpose.
    assign mem_rdata_out = mem_re_in ? mem[mem_addr_in[7:0]] : ~mem[mem_addr_in[7:0]];
    assign io_rdata_out  = io_re_in ? io[io_addr_in] : ~io[io_addr_in];

    // Stores land at the clock edge; a bit clear uses the one-hot mask on the data lines.
    always @(posedge clk_sys_in) begin
        if (mem_we_in) mem[mem_addr_in[7:0]] <= mem_wdata_in;
        if (io_we_in) io[io_addr_in] <= io_wdata_in;
        if (io_clr_in) io[io_addr_in] <= io[io_addr_in] & ~io_wdata_in;
    end
endmodule : bfl_mem_model
`default_nettype wire

/* File: tb/bfl_exec_test.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module bfl_exec_test;
    logic                   clk_sys_in = 1'b0;
    logic                   sys_rst_in = 1'b1;
    logic                   ce = 1'b1;
    logic                   vld = 1'b0;
    bfl_pkg::bfl_op_t       op = bfl_pkg::OP_NO_OPERATION;
    bfl_pkg::bfl_ptr_mode_t pm = bfl_pkg::PM_PLAIN;
    logic [3:0]             rg = 4'h0;
    logic [2:0]             bt = 3'h0;
    logic [15:0]            ad = 16'h0000;
    bit                     at_edge = 1'b0;
    int                     miscompares = 0;
    int                     n_tests = 0;
    wire logic              rdy, mwe, mre, iwe, ire, clr, wdg, slp, brk;
    wire logic [15:0]       madr, sp;
    wire logic [7:0]        mwd, mrd, iwd, ird, fl;
    wire logic [5:0]        iadr;

    bfl_exec i_bfl_exec (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
        .instr_valid_in(vld), .instr_op_in(op), .instr_rd_in(rg), .instr_rr_in(rg ^ ad[11:8]),
        .instr_bit_in(bt), .instr_ptr_sel_in(ad[13:12]), .instr_ptr_mode_in(pm),
        .instr_addr_in(ad), .instr_imm_in(ad[7:0]), .mem_rdata_in(mrd), .io_rdata_in(ird),
        .instr_ready_out(rdy), .mem_addr_out(madr), .mem_wdata_out(mwd), .mem_we_out(mwe),
        .mem_re_out(mre), .io_addr_out(iadr), .io_wdata_out(iwd), .io_we_out(iwe),
        .io_re_out(ire), .io_bit_clear_out(clr), .status_flags_out(fl), .stack_ptr_out(sp),
        .wdog_restart_out(wdg), .sleep_req_out(slp), .break_req_out(brk));
    bfl_mem_model i_bfl_mem_model (.clk_sys_in(clk_sys_in), .mem_addr_in(madr),
        .mem_wdata_in(mwd), .mem_we_in(mwe), .mem_re_in(mre), .io_addr_in(iadr),
        .io_wdata_in(iwd), .io_we_in(iwe), .io_re_in(ire), .io_clr_in(clr),
        .mem_rdata_out(mrd), .io_rdata_out(ird));

    // Free-running 50 MHz clock.
    always #10 clk_sys_in = ~clk_sys_in;

    task automatic conclude();
        if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    // Offer one op at an edge, wait boundedly for the take, then settle into cycle 1.
    task automatic go(bfl_pkg::bfl_op_t o, logic [3:0] r, logic [15:0] a, logic [2:0] b = 3'h0,
                      bfl_pkg::bfl_ptr_mode_t m = bfl_pkg::PM_PLAIN, bit hold = 1'b0);
        int n;
        if (!at_edge) @(posedge clk_sys_in);
        op <= o;
        rg <= r;
        ad <= a;
        bt <= b;
        pm <= m;
        vld <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            miscompares++;
            conclude();
        end
        at_edge = hold;
        if (!hold) begin
            vld <= 1'b0;
            #1;
        end
    endtask : go

    // Read a working register back by storing it to a spare data address.
    task automatic peek(logic [3:0] r, logic [7:0] e);
        go(bfl_pkg::OP_DIRECT_WRITE, r, 16'h00f0);
        `CHK("stored byte", {1'b1, 16'h00f0, e}, {mwe, madr, mwd})
    endtask : peek

    // Force every flag high in turn, then low in turn.
    task automatic t_flags();
        logic [7:0] e;
        e = 8'h00;
        for (int b = 0; b < 16; b++) begin
            e = b < 8 ? e | (8'h01 << b[2:0]) : e & ~(8'h01 << b[2:0]);
            go(b < 8 ? bfl_pkg::OP_FLAG_FORCE_ONE : bfl_pkg::OP_FLAG_FORCE_ZERO, 4'h0,
               16'h0000, b[2:0]);
            `CHK("flags", e, fl)
        end
    endtask : t_flags

    // Move bit 5 of one register into the transfer flag and out into bit 2 of another.
    task automatic t_bits();
        go(bfl_pkg::OP_IMMEDIATE_LOAD, 4'h3, 16'h0020);
        go(bfl_pkg::OP_BIT_TO_T, 4'h3, 16'h0000, 3'h5);
        `CHK("transfer flag", 8'h40, fl)
        go(bfl_pkg::OP_IMMEDIATE_LOAD, 4'h4, 16'h0001);
        go(bfl_pkg::OP_T_TO_BIT, 4'h4, 16'h0000, 3'h2);
        `CHK("flags", 8'h40, fl)
        peek(4'h4, 8'h05);
    endtask : t_bits

    // Walk the X pointer through every indirect mode.
    task automatic t_ptr();
        go(bfl_pkg::OP_IMMEDIATE_LOAD, 4'ha, 16'h0010);
        go(bfl_pkg::OP_IMMEDIATE_LOAD, 4'hb, 16'h0000);
        go(bfl_pkg::OP_INDIRECT_READ, 4'h1, 16'h0000, 3'h0, bfl_pkg::PM_POST_INC);
        `CHK("post-inc read", {2'b01, 16'h0010, 1'b0}, {mwe, mre, madr, rdy})
        peek(4'h1, 8'h4a);
        go(bfl_pkg::OP_INDIRECT_READ, 4'h2, 16'h0000, 3'h0, bfl_pkg::PM_PRE_DEC);
        `CHK("pre-dec read", {2'b01, 16'h0010, 1'b0}, {mwe, mre, madr, rdy})
        peek(4'h2, 8'h4a);
        go(bfl_pkg::OP_INDIRECT_WRITE, 4'h1, 16'h0000, 3'h0, bfl_pkg::PM_PRE_DEC);
        `CHK("pre-dec write", {2'b10, 16'h000f, 8'h4a, 1'b0}, {mwe, mre, madr, mwd, rdy})
        go(bfl_pkg::OP_INDIRECT_WRITE, 4'h2, 16'h0000, 3'h0, bfl_pkg::PM_POST_INC);
        `CHK("post-inc write", {2'b10, 16'h000f, 1'b1}, {mwe, mre, madr, rdy})
        go(bfl_pkg::OP_INDIRECT_WRITE, 4'h1, 16'h1000, 3'h0, bfl_pkg::PM_POST_INC);
        peek(4'hc, 8'h01);
        go(bfl_pkg::OP_INDIRECT_READ, 4'h3, 16'h0000);
        `CHK("plain read", {2'b01, 16'h0010, 1'b1}, {mwe, mre, madr, rdy})
    endtask : t_ptr

    // Direct load, then I/O write, read, bit clear and read back.
    task automatic t_io();
        go(bfl_pkg::OP_DIRECT_READ, 4'h5, 16'h0033);
        peek(4'h5, 8'h69);
        go(bfl_pkg::OP_IO_WRITE, 4'h5, 16'h0005);
        `CHK("io write", {3'b100, 6'h05, 8'h69}, {iwe, ire, clr, iadr, iwd})
        go(bfl_pkg::OP_IO_READ, 4'h6, 16'h0005);
        `CHK("io read", {3'b010, 6'h05}, {iwe, ire, clr, iadr})
        peek(4'h6, 8'h69);
        go(bfl_pkg::OP_IO_BIT_CLEAR, 4'h0, 16'h0005, 3'h3);
        `CHK("io clear", {3'b001, 6'h05, 8'h08, 8'h40}, {iwe, ire, clr, iadr, iwd, fl})
        go(bfl_pkg::OP_IO_READ, 4'h7, 16'h0005);
        peek(4'h7, 8'h61);
    endtask : t_io

    // Push one byte and pop it into another register.
    task automatic t_stack();
        go(bfl_pkg::OP_IMMEDIATE_LOAD, 4'h8, 16'h00c3);
        go(bfl_pkg::OP_PUSH, 4'h8, 16'h0000);
        `CHK("push", {2'b10, 16'h00ff, 8'hc3, 1'b0, 16'h00fe}, {mwe,mre,madr,mwd,rdy,sp})
        go(bfl_pkg::OP_POP, 4'h9, 16'h0000);
        `CHK("pop", {2'b01, 16'h00ff, 1'b0, 16'h00ff, 8'h40}, {mwe,mre,madr,rdy,sp,fl})
        peek(4'h9, 8'hc3);
    endtask : t_stack

    // Each core-control op gives only its own pulse and keeps the flags.
    task automatic t_ctrl();
        bfl_pkg::bfl_op_t ops [4] = '{bfl_pkg::OP_NO_OPERATION, bfl_pkg::OP_BREAK,
                                      bfl_pkg::OP_SLEEP, bfl_pkg::OP_WATCHDOG_RESTART};
        logic [2:0] ex [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
        for (int i = 0; i < 4; i++) begin
            go(ops[i], 4'h0, 16'h0000);
            `CHK("control", {ex[i], 8'h40, 1'b1}, {brk, slp, wdg, fl, rdy})
        end
    endtask : t_ctrl

    // A load followed at once by a store of the same register.
    task automatic t_back();
        go(bfl_pkg::OP_IMMEDIATE_LOAD, 4'h2, 16'h005e, 3'h0, bfl_pkg::PM_PLAIN, 1'b1);
        peek(4'h2, 8'h5e);
        go(bfl_pkg::OP_REGISTER_COPY, 4'h3, 16'h0100);
        peek(4'h3, 8'h5e);
    endtask : t_back

    // Reset for six cycles, then run every scenario.
    initial begin
        repeat (6) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        t_flags();
        t_bits();
        t_ptr();
        t_io();
        t_stack();
        t_ctrl();
        t_back();
        conclude();
    end
endmodule : bfl_exec_test
`default_nettype wire
